// file: rtl/rtv_pkg.sv
// Purpose: shared constants for the routing table valid controls block
// Assumes: 200 MHz clk, configuration access to one dword register
// Notes:   bit positions refer to the common control one register
package rtv_pkg;

    // register placement in the protocol layer configuration structure
    localparam logic [11:0] CTRL1_OFFSET      = 12'h004;

    // field positions inside common control one
    localparam int          AGENT_VALID_BIT   = 5;
    localparam int          REQ_VALID_BIT     = 6;
    localparam int          HOME_VALID_BIT    = 7;
    localparam int          PORTAL_EN_BIT     = 8;
    localparam int          RSVD_LO_BIT       = 9;
    localparam int          RSVD_HI_BIT       = 15;

    // values after reset
    localparam logic        TABLE_VALID_RST   = 1'b0;
    localparam logic        PORTAL_EN_RST     = 1'b0;
    localparam logic        READY_RST         = 1'b0;

    // multiport capability code that ties the snoop map to the agent map
    localparam logic [2:0]  MPC_ALL_ONES      = 3'h7;

    // settle time after a table is declared complete
    localparam int          CLK_PERIOD_PS     = 5000;
    localparam int          SETTLE_NS         = 50;
    localparam int          SETTLE_CYCLES     =
        (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SETTLE_W          = 8;

    // number of tracked tables
    localparam int          NUM_TABLES        = 3;
    localparam int          TBL_AGENT         = 0;
    localparam int          TBL_REQ           = 1;
    localparam int          TBL_HOME          = 2;

    typedef enum logic [0:0] {
        RTV_IDLE   = 1'b0,
        RTV_SETTLE = 1'b1
    } rtv_settle_t;

endpackage : rtv_pkg

// file: rtl/rtv_edge_track.sv
// Purpose: watch one table valid bit for edges and time the settle window
// Assumes: level comes from a register on the same clock
// Notes:   a fall marks the table torn until the next rise
`timescale 1ns/1ps
module rtv_edge_track (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic level,
    output logic      rise_done,
    output logic      busy,
    output logic      torn
);

    logic                           prev_q,  prev_d;
    logic                           torn_q,  torn_d;
    logic                           done_q,  done_d;
    rtv_pkg::rtv_settle_t           st_q,    st_d;
    logic [rtv_pkg::SETTLE_W-1:0]   cnt_q,   cnt_d;

    always_comb begin
        prev_d = level;
        torn_d = torn_q;
        done_d = 1'b0;
        st_d   = st_q;
        cnt_d  = cnt_q;
        if (prev_q && !level) begin
            torn_d = 1'b1;
            st_d   = rtv_pkg::RTV_IDLE;
        end
        unique case (st_q)
            rtv_pkg::RTV_IDLE: begin
                if (!prev_q && level) begin
                    torn_d = 1'b0;
                    st_d   = rtv_pkg::RTV_SETTLE;
                    cnt_d  = rtv_pkg::SETTLE_W'(rtv_pkg::SETTLE_CYCLES - 1);
                end
            end
            rtv_pkg::RTV_SETTLE: begin
                // a fall mid-settle abandons the completion
                if (!level) begin
                    st_d = rtv_pkg::RTV_IDLE;
                end else if (cnt_q == '0) begin
                    st_d   = rtv_pkg::RTV_IDLE;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 1'b0;
            torn_q <= 1'b0;
            done_q <= 1'b0;
            st_q   <= rtv_pkg::RTV_IDLE;
            cnt_q  <= '0;
        end else begin
            prev_q <= prev_d;
            torn_q <= torn_d;
            done_q <= done_d;
            st_q   <= st_d;
            cnt_q  <= cnt_d;
        end
    end

    assign rise_done = done_q;
    assign busy      = (st_q == rtv_pkg::RTV_SETTLE);
    assign torn      = torn_q;

endmodule : rtv_edge_track

// file: rtl/rtv_ctrl.sv
// Purpose: table valid bits and portal enable of common control one
// Assumes: configuration access on clk; capability inputs are static
// Notes:   bits 4:0 and 31:16 of the register live elsewhere, read 0 here
//
// Notes on behaviour
// - whole agent map usable only while its table valid bit is one.
// - with multiport capability 111b the agent bit also gates snoop map.
// - per-entry agent valid bits still gate each mapping beneath table bit.
// - software sets agent bit 0-to-1 when map built; device sees completion.
// - agent bit fall may drop discovery ready; rise may delay it.
// - static target id taken from pool regenerated after agent bit rise.
// - requester map usable only while its valid bit set, entries gate.
// - device with a requesting agent implements the requester map.
// - requester bit rising 0-to-1 marks that table complete.
// - requester bit fall may drop discovery ready; rise may delay it.
// - home map usable only while its valid bit set, entries gate.
// - device with memory-expanding home agent implements the home map.
// - forwarding device implements home map to pick local or egress slave.
// - home bit rising 0-to-1 marks that table complete.
// - home bit fall may drop discovery ready; rise may delay it.
// - portal enable bit 8 turns the portal on when capable.
// - portal enable clears on reset but survives function-level reset.
// - mesh topology on routes snoop responses through the snoop map.
`timescale 1ns/1ps
module rtv_ctrl #(
    parameter int AGENT_ENTRIES = 64,
    parameter int REQ_ENTRIES   = 16,
    parameter int HOME_ENTRIES  = 16,
    parameter int TGT_W         = 6,
    parameter bit HAS_REQ_MAP   = 1'b1,
    parameter bit HAS_HOME_MAP  = 1'b1
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     flr,
    input  wire logic                     cfg_wr,
    input  wire logic                     cfg_rd,
    input  wire logic [11:0]              cfg_addr,
    input  wire logic [31:0]              cfg_wdata,
    input  wire logic [3:0]               cfg_be,
    output logic      [31:0]              cfg_rdata,
    output logic                          cfg_rvalid,
    input  wire logic [2:0]               multiport_capability,
    input  wire logic                     service_portal_capable,
    input  wire logic                     mesh_topology_on,
    input  wire logic                     device_ready_in,
    input  wire logic [AGENT_ENTRIES-1:0] agent_entry_valid,
    input  wire logic [AGENT_ENTRIES-1:0] snoop_entry_valid,
    input  wire logic [REQ_ENTRIES-1:0]   req_entry_valid,
    input  wire logic [HOME_ENTRIES-1:0]  home_entry_valid,
    input  wire logic [TGT_W-1:0]         pool_target_identifier,
    output logic                          agent_map_table_valid,
    output logic                          requester_addr_map_valid,
    output logic                          home_addr_map_valid,
    output logic                          service_portal_enable,
    output logic                          service_portal_active,
    output logic                          discovery_ready_status,
    output logic                          snoop_route_via_snoop_map,
    output logic [AGENT_ENTRIES-1:0]      agent_map_use,
    output logic [AGENT_ENTRIES-1:0]      snoop_map_use,
    output logic [REQ_ENTRIES-1:0]        req_map_use,
    output logic [HOME_ENTRIES-1:0]       home_map_use,
    output logic                          requester_map_complete,
    output logic                          home_map_complete,
    output logic [TGT_W-1:0]              static_target_identifier,
    output logic                          static_target_valid
);

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic              agent_valid_q,  agent_valid_d;
    logic              req_valid_q,    req_valid_d;
    logic              home_valid_q,   home_valid_d;
    logic              portal_en_q,    portal_en_d;
    logic [31:0]       rdata_q,        rdata_d;
    logic              rvalid_q,       rvalid_d;
    logic              hit;

    assign hit = (cfg_addr == rtv_pkg::CTRL1_OFFSET);

    always_comb begin
        agent_valid_d = agent_valid_q;
        req_valid_d   = req_valid_q;
        home_valid_d  = home_valid_q;
        portal_en_d   = portal_en_q;
        rdata_d       = 32'h0000_0000;
        rvalid_d      = cfg_rd;
        if (cfg_wr && hit && cfg_be[0]) begin
            agent_valid_d = cfg_wdata[rtv_pkg::AGENT_VALID_BIT];
            // absent tables keep their bit at zero
            req_valid_d   = HAS_REQ_MAP  && cfg_wdata[rtv_pkg::REQ_VALID_BIT];
            home_valid_d  = HAS_HOME_MAP && cfg_wdata[rtv_pkg::HOME_VALID_BIT];
        end
        if (cfg_wr && hit && cfg_be[1]) begin
            // stored even when not capable; software must keep it zero
            portal_en_d = cfg_wdata[rtv_pkg::PORTAL_EN_BIT];
        end
        // function-level reset tears the maps down but spares the portal
        if (flr) begin
            agent_valid_d = rtv_pkg::TABLE_VALID_RST;
            req_valid_d   = rtv_pkg::TABLE_VALID_RST;
            home_valid_d  = rtv_pkg::TABLE_VALID_RST;
        end
        if (cfg_rd && hit) begin
            rdata_d[rtv_pkg::AGENT_VALID_BIT] = agent_valid_q;
            rdata_d[rtv_pkg::REQ_VALID_BIT]   = req_valid_q;
            rdata_d[rtv_pkg::HOME_VALID_BIT]  = home_valid_q;
            rdata_d[rtv_pkg::PORTAL_EN_BIT]   = portal_en_q;
            // reserved field stays zero on read
            rdata_d[rtv_pkg::RSVD_HI_BIT:rtv_pkg::RSVD_LO_BIT] = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            agent_valid_q <= rtv_pkg::TABLE_VALID_RST;
            req_valid_q   <= rtv_pkg::TABLE_VALID_RST;
            home_valid_q  <= rtv_pkg::TABLE_VALID_RST;
            portal_en_q   <= rtv_pkg::PORTAL_EN_RST;
            rdata_q       <= 32'h0000_0000;
            rvalid_q      <= 1'b0;
        end else begin
            agent_valid_q <= agent_valid_d;
            req_valid_q   <= req_valid_d;
            home_valid_q  <= home_valid_d;
            portal_en_q   <= portal_en_d;
            rdata_q       <= rdata_d;
            rvalid_q      <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion tracking per table

    logic [rtv_pkg::NUM_TABLES-1:0] tbl_level;
    logic [rtv_pkg::NUM_TABLES-1:0] tbl_done;
    logic [rtv_pkg::NUM_TABLES-1:0] tbl_busy;
    logic [rtv_pkg::NUM_TABLES-1:0] tbl_torn;

    assign tbl_level[rtv_pkg::TBL_AGENT] = agent_valid_q;
    assign tbl_level[rtv_pkg::TBL_REQ]   = req_valid_q;
    assign tbl_level[rtv_pkg::TBL_HOME]  = home_valid_q;

    for (genvar t = 0; t < rtv_pkg::NUM_TABLES; t++) begin : g_track
        rtv_edge_track u_track (
            .clk       (clk),
            .rstn      (rstn),
            .level     (tbl_level[t]),
            .rise_done (tbl_done[t]),
            .busy      (tbl_busy[t]),
            .torn      (tbl_torn[t])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // discovery ready, completion pulses and static target

    logic             ready_q,     ready_d;
    logic             req_cmp_q,   req_cmp_d;
    logic             home_cmp_q,  home_cmp_d;
    logic [TGT_W-1:0] tgt_q,       tgt_d;
    logic             tgt_vld_q,   tgt_vld_d;

    always_comb begin
        // torn tables drop readiness, settling ones hold it off
        ready_d = device_ready_in
                  && !tbl_torn[rtv_pkg::TBL_AGENT]
                  && !tbl_busy[rtv_pkg::TBL_AGENT]
                  && !tbl_torn[rtv_pkg::TBL_REQ]
                  && !tbl_busy[rtv_pkg::TBL_REQ]
                  && !tbl_torn[rtv_pkg::TBL_HOME]
                  && !tbl_busy[rtv_pkg::TBL_HOME];
        req_cmp_d  = tbl_done[rtv_pkg::TBL_REQ];
        home_cmp_d = tbl_done[rtv_pkg::TBL_HOME];
        tgt_d      = tgt_q;
        tgt_vld_d  = tgt_vld_q && agent_valid_q;
        // re-pick only once the pool has had time to regenerate
        if (tbl_done[rtv_pkg::TBL_AGENT]) begin
            tgt_d     = pool_target_identifier;
            tgt_vld_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ready_q    <= rtv_pkg::READY_RST;
            req_cmp_q  <= 1'b0;
            home_cmp_q <= 1'b0;
            tgt_q      <= '0;
            tgt_vld_q  <= 1'b0;
        end else begin
            ready_q    <= ready_d;
            req_cmp_q  <= req_cmp_d;
            home_cmp_q <= home_cmp_d;
            tgt_q      <= tgt_d;
            tgt_vld_q  <= tgt_vld_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // map gating; entries are registered so routing sees one clean edge

    logic [AGENT_ENTRIES-1:0] agent_use_q,  agent_use_d;
    logic [AGENT_ENTRIES-1:0] snoop_use_q,  snoop_use_d;
    logic [REQ_ENTRIES-1:0]   req_use_q,    req_use_d;
    logic [HOME_ENTRIES-1:0]  home_use_q,   home_use_d;
    logic                     snoop_tied;
    logic                     mesh_q,       mesh_d;
    logic                     portal_act_q, portal_act_d;

    assign snoop_tied = (multiport_capability == rtv_pkg::MPC_ALL_ONES);

    for (genvar a = 0; a < AGENT_ENTRIES; a++) begin : g_agent
        assign agent_use_d[a] = agent_valid_q && agent_entry_valid[a];
        assign snoop_use_d[a] = snoop_entry_valid[a] && (!snoop_tied || agent_valid_q);
    end

    for (genvar r = 0; r < REQ_ENTRIES; r++) begin : g_req
        // absent map never enables an entry
        assign req_use_d[r] = HAS_REQ_MAP && req_valid_q && req_entry_valid[r];
    end

    for (genvar h = 0; h < HOME_ENTRIES; h++) begin : g_home
        assign home_use_d[h] = HAS_HOME_MAP && home_valid_q && home_entry_valid[h];
    end

    always_comb begin
        mesh_d       = mesh_topology_on;
        portal_act_d = portal_en_q && service_portal_capable;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            agent_use_q  <= '0;
            snoop_use_q  <= '0;
            req_use_q    <= '0;
            home_use_q   <= '0;
            mesh_q       <= 1'b0;
            portal_act_q <= 1'b0;
        end else begin
            agent_use_q  <= agent_use_d;
            snoop_use_q  <= snoop_use_d;
            req_use_q    <= req_use_d;
            home_use_q   <= home_use_d;
            mesh_q       <= mesh_d;
            portal_act_q <= portal_act_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign cfg_rdata                 = rdata_q;
    assign cfg_rvalid                = rvalid_q;
    assign agent_map_table_valid     = agent_valid_q;
    assign requester_addr_map_valid  = req_valid_q;
    assign home_addr_map_valid       = home_valid_q;
    assign service_portal_enable     = portal_en_q;
    assign service_portal_active     = portal_act_q;
    assign discovery_ready_status    = ready_q;
    assign snoop_route_via_snoop_map = mesh_q;
    assign agent_map_use             = agent_use_q;
    assign snoop_map_use             = snoop_use_q;
    assign req_map_use               = req_use_q;
    assign home_map_use              = home_use_q;
    assign requester_map_complete    = req_cmp_q;
    assign home_map_complete         = home_cmp_q;
    assign static_target_identifier  = tgt_q;
    assign static_target_valid       = tgt_vld_q;

endmodule : rtv_ctrl

// file: tb/rtv_ctrl_assertions.sv
// Purpose: port checks for the table valid and portal enable controls
// Assumes: one clk domain, rstn async active low
// Notes:   windows follow the designer's stated latencies
`timescale 1ns/1ps
module rtv_ctrl_chk #(
    parameter int AGENT_ENTRIES = 64
) (
    input wire logic                     clk,
    input wire logic                     rstn,
    input wire logic                     flr,
    input wire logic                     cfg_wr,
    input wire logic                     cfg_rd,
    input wire logic [11:0]              cfg_addr,
    input wire logic [31:0]              cfg_wdata,
    input wire logic [3:0]               cfg_be,
    input wire logic [31:0]              cfg_rdata,
    input wire logic                     cfg_rvalid,
    input wire logic [2:0]               multiport_capability,
    input wire logic                     service_portal_capable,
    input wire logic                     mesh_topology_on,
    input wire logic [AGENT_ENTRIES-1:0] agent_entry_valid,
    input wire logic [AGENT_ENTRIES-1:0] snoop_entry_valid,
    input wire logic                     agent_map_table_valid,
    input wire logic                     requester_addr_map_valid,
    input wire logic                     service_portal_enable,
    input wire logic                     service_portal_active,
    input wire logic                     discovery_ready_status,
    input wire logic                     snoop_route_via_snoop_map,
    input wire logic [AGENT_ENTRIES-1:0] agent_map_use,
    input wire logic [AGENT_ENTRIES-1:0] snoop_map_use,
    input wire logic                     requester_map_complete
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    rd_answer_a: assert property ($past(rstn) |-> cfg_rvalid == $past(cfg_rd))
        else $error("read answer missing or extra");
    rsvd_zero_a: assert property (cfg_rdata[15:9] == 7'h00 && cfg_rdata[4:0] == 5'h00
        && cfg_rdata[31:16] == 16'h0000)
        else $error("reserved read bits not zero");
    agent_wr_a: assert property (cfg_wr && cfg_addr == rtv_pkg::CTRL1_OFFSET && cfg_be[0]
        && !flr |=> agent_map_table_valid == $past(cfg_wdata[rtv_pkg::AGENT_VALID_BIT]))
        else $error("agent table bit write lost");
    flr_keep_a: assert property (flr && !cfg_wr
        |=> !agent_map_table_valid && $stable(service_portal_enable))
        else $error("function reset handled wrongly");
    portal_act_a: assert property ($past(rstn) |-> service_portal_active ==
        ($past(service_portal_enable) && $past(service_portal_capable)))
        else $error("portal active wrong");
    agent_use_a: assert property ($past(rstn) |-> agent_map_use ==
        ($past(agent_entry_valid) & {AGENT_ENTRIES{$past(agent_map_table_valid)}}))
        else $error("agent map use wrong");
    snoop_use_a: assert property ($past(rstn) |-> snoop_map_use ==
        ($past(snoop_entry_valid) & {AGENT_ENTRIES{$past(multiport_capability)
        != rtv_pkg::MPC_ALL_ONES || $past(agent_map_table_valid)}}))
        else $error("snoop map use wrong");
    mesh_route_a: assert property ($past(rstn) |->
        snoop_route_via_snoop_map == $past(mesh_topology_on))
        else $error("snoop route select wrong");
    ready_drop_a: assert property ($fell(agent_map_table_valid) |->
        ##[1:3] !discovery_ready_status)
        else $error("ready kept after table torn");
    req_done_a: assert property ($rose(requester_addr_map_valid) ##1
        requester_addr_map_valid [*8] |-> ##[1:6] requester_map_complete)
        else $error("requester completion missing");
    ////////////////////////////////////////////////////////////////////////////////
    cover property (requester_map_complete);
    cover property (flr ##1 service_portal_enable);
    cover property ($fell(agent_map_table_valid));
endmodule : rtv_ctrl_chk

bind rtv_ctrl rtv_ctrl_chk #(.AGENT_ENTRIES(AGENT_ENTRIES)) chk_u (.*);

// file: tb/routing_table_valid_controls_test.sv
// Purpose: self-checking bench for the table valid and portal controls
// Assumes: reads scored from a queue of expected words
// Notes:   narrow entry vectors keep mismatch lines readable
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected t=%0t got %h want %h", $time, a, e); end end
module routing_table_valid_controls_test;
    localparam int AE = 8;
    localparam int RE = 4;
    localparam int TW = 6;
    localparam logic [11:0] OFS = rtv_pkg::CTRL1_OFFSET;
    logic clk, rstn, flr, cfg_wr, cfg_rd, cfg_rvalid, service_portal_capable;
    logic mesh_topology_on, device_ready_in, static_target_valid;
    logic agent_map_table_valid, requester_addr_map_valid, home_addr_map_valid;
    logic service_portal_enable, service_portal_active, discovery_ready_status;
    logic snoop_route_via_snoop_map, requester_map_complete, home_map_complete;
    logic [11:0]   cfg_addr;
    logic [31:0]   cfg_wdata, cfg_rdata, mdl, rnd, ev;
    logic [3:0]    cfg_be;
    logic [2:0]    multiport_capability;
    logic [AE-1:0] agent_entry_valid, snoop_entry_valid, agent_map_use, snoop_map_use;
    logic [RE-1:0] req_entry_valid, home_entry_valid, req_map_use, home_map_use;
    logic [TW-1:0] pool_target_identifier, static_target_identifier;
    logic [31:0]   exp_q[$];
    int            n_errors, checks, i, k;

    rtv_ctrl #(.AGENT_ENTRIES(AE), .REQ_ENTRIES(RE), .HOME_ENTRIES(RE), .TGT_W(TW)) dut_u (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        cfg_wr    <= 1'b1;
        cfg_addr  <= a;
        cfg_wdata <= d;
        cfg_be    <= be;
        @(posedge clk);
        cfg_wr    <= 1'b0;
        if (a == OFS && be[0]) mdl[7:5] = d[7:5];
        if (a == OFS && be[1]) mdl[8] = d[8];
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        cfg_rd   <= 1'b1;
        cfg_addr <= a;
        exp_q.push_back(a == OFS ? mdl : 32'h0);
        @(posedge clk);
        cfg_rd   <= 1'b0;
    endtask : rd

    // all three tables rise together; ready must hold off while they settle
    task automatic settle();
        wr(OFS, 32'he0, 4'h1);
        cyc(4);
        `CHK(discovery_ready_status, 1'b0)
        for (i = 0; i < 30 && requester_map_complete !== 1'b1; i++) @(posedge clk);
        if (i == 30) n_errors++;
        if (i == 30) summarize();
        `CHK(home_map_complete, 1'b1)
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (cfg_rvalid === 1'b1 && exp_q.size() > 0) begin
            ev = exp_q.pop_front();
            `CHK(cfg_rdata, ev)
        end else if (rstn === 1'b1 && cfg_rvalid !== 1'b0)
            `CHK(cfg_rvalid, 1'b0)
    end

    initial begin
        rnd = lfsr(32'hff0d);
        {rstn, flr, cfg_wr, cfg_rd, mesh_topology_on} = 5'h00;
        {cfg_addr, cfg_wdata, cfg_be, mdl} = '0;
        multiport_capability   = 3'h7;
        service_portal_capable = 1'b1;
        device_ready_in        = 1'b1;
        pool_target_identifier = 6'h2a;
        {home_entry_valid, req_entry_valid, snoop_entry_valid, agent_entry_valid} = rnd[23:0];
        cyc(5);
        rstn <= 1'b1;
        rd(OFS);
        rd(12'h00c);
        for (k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            wr(rnd[0] ? OFS : 12'h008, rnd | 32'h0000fe00, rnd[12:9]);
            mesh_topology_on <= rnd[20];
            rd(OFS);
        end
        wr(OFS, 32'h0, 4'h1);
        settle();
        cyc(3);
        `CHK(discovery_ready_status, 1'b1)
        `CHK(static_target_valid, 1'b1)
        `CHK(static_target_identifier, 6'h2a)
        `CHK(requester_addr_map_valid, 1'b1)
        `CHK(home_addr_map_valid, 1'b1)
        `CHK(snoop_route_via_snoop_map, mesh_topology_on)
        wr(OFS, 32'h0, 4'h1);
        pool_target_identifier <= 6'h15;
        cyc(3);
        `CHK(discovery_ready_status, 1'b0)
        `CHK(static_target_valid, 1'b0)
        settle();
        cyc(3);
        `CHK(static_target_identifier, 6'h15)
        wr(OFS, 32'hc0, 4'h1);
        cyc(3);
        `CHK(agent_map_use, '0)
        `CHK(snoop_map_use, '0)
        `CHK(req_map_use, req_entry_valid)
        `CHK(home_map_use, home_entry_valid)
        multiport_capability <= 3'h3;
        wr(OFS, 32'he0, 4'h1);
        cyc(3);
        `CHK(snoop_map_use, snoop_entry_valid)
        `CHK(agent_map_use, agent_entry_valid)
        wr(OFS, 32'h100, 4'h2);
        cyc(2);
        `CHK(service_portal_active, 1'b1)
        flr <= 1'b1;
        @(posedge clk);
        flr <= 1'b0;
        mdl[7:5] = 3'h0;
        rd(OFS);
        `CHK(agent_map_table_valid, 1'b0)
        `CHK(service_portal_enable, 1'b1)
        // let the read answer land before reset wipes it
        cyc(2);
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        mdl = '0;
        rd(OFS);
        `CHK(service_portal_enable, 1'b0)
        cyc(4);
        `CHK(exp_q.size(), 0)
        summarize();
    end
endmodule : routing_table_valid_controls_test
